// >>> logic/adc_diag_defs.vh
/*
 Constants of the diagnostic, chop and modulator delay register bank.
 Assumes it is included by its bare name from logic/ sources.
*/
// Behaviour
// - group assignment steers A or B selection
// - test selections at [2:0] and [6:4]
// - code 011 applies positive full scale
// - code 100 applies negative full scale
// - code 101 applies zero scale
// - diag mux control at 0x57, reset 0x00
// - delay field 00 none, 11 all
// - delay field 01 ch0/1, 10 ch2/3
// - modulator delay control at 0x58, reset 0x02
// - chop control 0x59, reset 0x0A, fields
// - chop code 01 divides modulator clock by 8
// - chop code 10 divides modulator clock by 32
// - receive select bit connects channel to diagnostic
`ifndef ADC_DIAG_DEFS_VH
`define ADC_DIAG_DEFS_VH

// register indices; byte address is four times the index
`define GROUP_ASSIGN_IDX        7'h03
`define DIAG_RX_SELECT_IDX      7'h56
`define DIAG_MUX_CONTROL_IDX    7'h57
`define MOD_DELAY_CONTROL_IDX   7'h58
`define CHOP_RATE_CONTROL_IDX   7'h59

// reset values
`define GROUP_ASSIGN_RST        8'h00
`define DIAG_RX_SELECT_RST      8'h00
`define DIAG_MUX_CONTROL_RST    8'h00
`define MOD_DELAY_CONTROL_RST   8'h02
`define CHOP_RATE_CONTROL_RST   8'h0a

// writable bit masks
`define GROUP_ASSIGN_MASK       8'h0f
`define DIAG_RX_SELECT_MASK     8'h33
`define DIAG_MUX_CONTROL_MASK   8'h77
`define MOD_DELAY_CONTROL_MASK  8'h0f
`define CHOP_RATE_CONTROL_MASK  8'h0f

// field positions
`define GRP_A_SEL_MSB           2
`define GRP_A_SEL_LSB           0
`define GRP_B_SEL_MSB           6
`define GRP_B_SEL_LSB           4
`define DELAY_EN_MSB            3
`define DELAY_EN_LSB            2
`define GRP_A_CHOP_MSB          3
`define GRP_A_CHOP_LSB          2
`define GRP_B_CHOP_MSB          1
`define GRP_B_CHOP_LSB          0
`define RX_CH0_BIT              0
`define RX_CH1_BIT              1
`define RX_CH2_BIT              4
`define RX_CH3_BIT              5

// test selection codes
`define TEST_OFF                3'h0
`define TEST_POS_FULL           3'h3
`define TEST_NEG_FULL           3'h4
`define TEST_ZERO               3'h5

// delayed clock codes
`define DELAY_NONE              2'h0
`define DELAY_CH01              2'h1
`define DELAY_CH23              2'h2
`define DELAY_ALL               2'h3

// chop codes and divide ratios in modulator clocks
`define CHOP_DIV8               2'h1
`define CHOP_DIV32              2'h2
`define CHOP_RATIO_FAST         8
`define CHOP_RATIO_SLOW         32

// axi responses
`define RESP_OKAY               2'h0
`define RESP_SLVERR             2'h2

`endif

// >>> logic/chop_rate_divider.v
/*
 Chop square wave generator for one channel group.
 Assumes aclk is the modulator clock and the rate code is synchronous.
*/
`timescale 1ns/1ps
`default_nettype none
`include "adc_diag_defs.vh"

module chop_rate_divider #(
   parameter integer FAST_RATIO = `CHOP_RATIO_FAST,
   parameter integer SLOW_RATIO = `CHOP_RATIO_SLOW
) (
   // clock and reset
   input  wire       aclk,
   input  wire       aresetn,
   // rate code from the chop register
   input  wire [1:0] rate_code,
   // chop phase
   output reg        chop_reg
);

   reg  [4:0] count_reg;
   reg  [1:0] code_reg;
   wire       fast;
   wire       slow;
   wire [4:0] half_last;

   assign fast      = (rate_code == `CHOP_DIV8);
   assign slow      = (rate_code == `CHOP_DIV32);
   assign half_last = fast ? FAST_RATIO[5:1] - 5'd1 : SLOW_RATIO[5:1] - 5'd1;

   // a rate change restarts the phase so no short half period is stretched
   always @(posedge aclk) begin
      if (!aresetn) begin
         count_reg <= 5'd0;
         chop_reg  <= 1'b0;
         code_reg  <= `CHOP_DIV32;
      end else begin
         code_reg <= rate_code;
         if ((!fast && !slow) || (code_reg != rate_code)) begin
            count_reg <= 5'd0;
            chop_reg  <= 1'b0;
         end else if (count_reg == half_last) begin
            count_reg <= 5'd0;
            chop_reg  <= ~chop_reg;
         end else begin
            count_reg <= count_reg + 5'd1;
         end
      end
   end

endmodule
`default_nettype wire

// >>> logic/adc_diag_config.v
/*
 Diagnostic multiplexer, modulator delay and chop register bank with an
 AXI4-Lite slave and per-channel control outputs for four channels.
 Assumes one clock (the modulator clock, aclk), a synchronous low reset,
 a master keeping one write and one read outstanding at most, and 32-bit
 data; registers sit at four times their index.
*/
`timescale 1ns/1ps
`default_nettype none
`include "adc_diag_defs.vh"

module adc_diag_config #(
   parameter integer ADDR_W = 9
) (
   // clock and reset
   input  wire              aclk,
   input  wire              aresetn,
   // write address channel
   input  wire [ADDR_W-1:0] s_axi_awaddr,
   input  wire [2:0]        s_axi_awprot,
   input  wire              s_axi_awvalid,
   output wire              s_axi_awready,
   // write data channel
   input  wire [31:0]       s_axi_wdata,
   input  wire [3:0]        s_axi_wstrb,
   input  wire              s_axi_wvalid,
   output wire              s_axi_wready,
   // write response channel
   output reg  [1:0]        s_axi_bresp,
   output reg               s_axi_bvalid,
   input  wire              s_axi_bready,
   // read address channel
   input  wire [ADDR_W-1:0] s_axi_araddr,
   input  wire [2:0]        s_axi_arprot,
   input  wire              s_axi_arvalid,
   output wire              s_axi_arready,
   // read data channel
   output reg  [31:0]       s_axi_rdata,
   output reg  [1:0]        s_axi_rresp,
   output reg               s_axi_rvalid,
   input  wire              s_axi_rready,
   // diagnostic voltage steering, one bit per channel
   output reg  [3:0]        diag_channel_connect,
   output reg  [3:0]        positive_full_scale_apply,
   output reg  [3:0]        negative_full_scale_apply,
   output reg  [3:0]        zero_scale_apply,
   // modulator clock delay, one bit per channel
   output reg  [3:0]        delayed_modulator_clock_enable,
   // chop phase, one bit per channel
   output reg  [3:0]        channel_chop
);

   localparam IDX_W = ADDR_W - 2;

   // register storage
   reg  [7:0]       group_assign_reg;
   reg  [7:0]       diag_rx_select_reg;
   reg  [7:0]       diag_mux_control_reg;
   reg  [7:0]       modulator_delay_control_reg;
   reg  [7:0]       chop_rate_control_reg;

   // write side holding state
   reg              aw_held_reg;
   reg              w_held_reg;
   reg  [IDX_W-1:0] aw_idx_reg;
   reg  [7:0]       wdata_reg;
   reg              wlane_reg;

   // read side
   wire [IDX_W-1:0] ar_idx;
   reg  [7:0]       read_byte;
   reg              read_hit;

   // write commit
   wire             commit;
   reg              write_hit;

   // derived fields
   wire [2:0]       group_a_test_voltage_select;
   wire [2:0]       group_b_test_voltage_select;
   wire [1:0]       delay_field;
   wire [1:0]       group_a_chop_rate;
   wire [1:0]       group_b_chop_rate;
   wire [3:0]       rx_per_channel;
   wire             group_a_chop;
   wire             group_b_chop;

   // per-channel next values
   wire [3:0]       connect_next;
   wire [3:0]       pos_next;
   wire [3:0]       neg_next;
   wire [3:0]       zero_next;
   reg  [3:0]       delay_next;
   wire [3:0]       chop_next;
   genvar           gi;

   // per-register store strobes
   wire             store;
   wire             store_assign;
   wire             store_rx_select;
   wire             store_mux;
   wire             store_delay;
   wire             store_chop;

   // the prot fields carry no meaning for this bank
   wire             unused_prot;
   assign unused_prot = ^{s_axi_awprot, s_axi_arprot,
                          s_axi_wstrb[3:1], s_axi_wdata[31:8]};

   // each write channel is taken once and held until the write commits
   assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
   assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign commit        = aw_held_reg && w_held_reg && !s_axi_bvalid;

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg <= 1'b0;
         w_held_reg  <= 1'b0;
         aw_idx_reg  <= {IDX_W{1'b0}};
         wdata_reg   <= 8'h00;
         wlane_reg   <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            aw_idx_reg  <= s_axi_awaddr[ADDR_W-1:2];
         end else if (commit) begin
            aw_held_reg <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata[7:0];
            wlane_reg  <= s_axi_wstrb[0];
         end else if (commit) begin
            w_held_reg <= 1'b0;
         end
      end
   end

   // decode of the held write address
   always @* begin
      case (aw_idx_reg)
         `GROUP_ASSIGN_IDX:      write_hit = 1'b1;
         `DIAG_RX_SELECT_IDX:    write_hit = 1'b1;
         `DIAG_MUX_CONTROL_IDX:  write_hit = 1'b1;
         `MOD_DELAY_CONTROL_IDX: write_hit = 1'b1;
         `CHOP_RATE_CONTROL_IDX: write_hit = 1'b1;
         default:                write_hit = 1'b0;
      endcase
   end

   // a clear strobe on lane 0 leaves the register untouched but answers okay
   assign store           = commit && wlane_reg;
   assign store_assign    = store && (aw_idx_reg == `GROUP_ASSIGN_IDX);
   assign store_rx_select = store && (aw_idx_reg == `DIAG_RX_SELECT_IDX);
   assign store_mux       = store && (aw_idx_reg == `DIAG_MUX_CONTROL_IDX);
   assign store_delay     = store && (aw_idx_reg == `MOD_DELAY_CONTROL_IDX);
   assign store_chop      = store && (aw_idx_reg == `CHOP_RATE_CONTROL_IDX);

   always @(posedge aclk) begin
      if (!aresetn) begin
         group_assign_reg <= `GROUP_ASSIGN_RST;
      end else if (store_assign) begin
         group_assign_reg <= wdata_reg & `GROUP_ASSIGN_MASK;
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         diag_rx_select_reg <= `DIAG_RX_SELECT_RST;
      end else if (store_rx_select) begin
         diag_rx_select_reg <= wdata_reg & `DIAG_RX_SELECT_MASK;
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         diag_mux_control_reg <= `DIAG_MUX_CONTROL_RST;
      end else if (store_mux) begin
         diag_mux_control_reg <= wdata_reg & `DIAG_MUX_CONTROL_MASK;
      end
   end

   // reserved low bits stored as written; keeping 0x2 is up to software
   always @(posedge aclk) begin
      if (!aresetn) begin
         modulator_delay_control_reg <= `MOD_DELAY_CONTROL_RST;
      end else if (store_delay) begin
         modulator_delay_control_reg <=
            wdata_reg & `MOD_DELAY_CONTROL_MASK;
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         chop_rate_control_reg <= `CHOP_RATE_CONTROL_RST;
      end else if (store_chop) begin
         chop_rate_control_reg <= wdata_reg & `CHOP_RATE_CONTROL_MASK;
      end
   end

   // write response one cycle after both halves are held
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `RESP_OKAY;
      end else if (commit) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= write_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // read decode; unused bits of every register read as zero
   assign ar_idx = s_axi_araddr[ADDR_W-1:2];

   always @* begin
      read_hit  = 1'b1;
      read_byte = 8'h00;
      case (ar_idx)
         `GROUP_ASSIGN_IDX:      read_byte = group_assign_reg;
         `DIAG_RX_SELECT_IDX:    read_byte = diag_rx_select_reg;
         `DIAG_MUX_CONTROL_IDX:  read_byte = diag_mux_control_reg;
         `MOD_DELAY_CONTROL_IDX: read_byte = modulator_delay_control_reg;
         `CHOP_RATE_CONTROL_IDX: read_byte = chop_rate_control_reg;
         default:                read_hit  = 1'b0;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= {24'h00_0000, read_byte};
         s_axi_rresp  <= read_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // field extraction
   assign group_a_test_voltage_select =
      diag_mux_control_reg[`GRP_A_SEL_MSB:`GRP_A_SEL_LSB];
   assign group_b_test_voltage_select =
      diag_mux_control_reg[`GRP_B_SEL_MSB:`GRP_B_SEL_LSB];
   assign delay_field =
      modulator_delay_control_reg[`DELAY_EN_MSB:`DELAY_EN_LSB];
   assign group_a_chop_rate =
      chop_rate_control_reg[`GRP_A_CHOP_MSB:`GRP_A_CHOP_LSB];
   assign group_b_chop_rate =
      chop_rate_control_reg[`GRP_B_CHOP_MSB:`GRP_B_CHOP_LSB];

   // receive bits are spread over bits 0, 1, 4 and 5
   assign rx_per_channel = {diag_rx_select_reg[`RX_CH3_BIT],
                            diag_rx_select_reg[`RX_CH2_BIT],
                            diag_rx_select_reg[`RX_CH1_BIT],
                            diag_rx_select_reg[`RX_CH0_BIT]};

   // one chop generator per group; channels pick by assignment
   chop_rate_divider group_a_divider (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .rate_code (group_a_chop_rate),
      .chop_reg  (group_a_chop)
   );

   chop_rate_divider group_b_divider (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .rate_code (group_b_chop_rate),
      .chop_reg  (group_b_chop)
   );

   // per-channel steering of test voltage and chop phase
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : steer
         wire       in_group_b;
         wire       rx_on;
         wire [2:0] ch_sel;
         // assignment bit low means group A
         assign in_group_b = group_assign_reg[gi];
         assign ch_sel     = in_group_b ? group_b_test_voltage_select
                                        : group_a_test_voltage_select;
         assign chop_next[gi] = in_group_b ? group_b_chop
                                           : group_a_chop;
         // a channel not enabled for receive never sees a test voltage
         assign rx_on            = rx_per_channel[gi];
         assign connect_next[gi] = rx_on;
         // reserved codes match none of the three checks
         assign pos_next[gi]  = rx_on && (ch_sel == `TEST_POS_FULL);
         assign neg_next[gi]  = rx_on && (ch_sel == `TEST_NEG_FULL);
         assign zero_next[gi] = rx_on && (ch_sel == `TEST_ZERO);
      end
   endgenerate

   // delayed modulator clock per channel pair
   always @* begin
      case (delay_field)
         `DELAY_NONE: delay_next = 4'h0;
         `DELAY_CH01: delay_next = 4'h3;
         `DELAY_CH23: delay_next = 4'hc;
         `DELAY_ALL:  delay_next = 4'hf;
         default:     delay_next = 4'h0;
      endcase
   end

   // outputs registered so the analog side sees glitch-free levels
   always @(posedge aclk) begin
      if (!aresetn) begin
         diag_channel_connect      <= 4'h0;
         positive_full_scale_apply <= 4'h0;
         negative_full_scale_apply <= 4'h0;
         zero_scale_apply          <= 4'h0;
      end else begin
         diag_channel_connect      <= connect_next;
         positive_full_scale_apply <= pos_next;
         negative_full_scale_apply <= neg_next;
         zero_scale_apply          <= zero_next;
      end
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         delayed_modulator_clock_enable <= 4'h0;
      end else begin
         delayed_modulator_clock_enable <= delay_next;
      end
   end

   // chop phase reaches the channel one cycle after its generator
   always @(posedge aclk) begin
      if (!aresetn) begin
         channel_chop <= 4'h0;
      end else begin
         channel_chop <= chop_next;
      end
   end

endmodule
`default_nettype wire

// >>> verif/adc_diag_checker.sv
/*
 Checker for the diagnostic, delay and chop register bank.
 Assumes it is bound to adc_diag_config and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module adc_diag_checker (
   // clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // register bus
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   // channel controls
   input wire logic [3:0]  diag_channel_connect,
   input wire logic [3:0]  positive_full_scale_apply,
   input wire logic [3:0]  negative_full_scale_apply,
   input wire logic [3:0]  zero_scale_apply,
   input wire logic [3:0]  delayed_modulator_clock_enable
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_both_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_b_answer;
      !s_axi_bvalid ##1 s_axi_bvalid;
   endsequence
   property p_b_timing;
      s_both_taken |=> s_b_answer;
   endproperty
   a_b_timing: assert property (p_b_timing)
      else $error("write response not two cycles after both halves");
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold)
      else $error("write response dropped before bready");
   property p_r_timing;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_r_timing: assert property (p_r_timing)
      else $error("read data not one cycle after address");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold)
      else $error("read data changed before rready");
   property p_refuse;
      (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
         and (s_axi_rvalid |-> !s_axi_arready);
   endproperty
   a_refuse: assert property (p_refuse)
      else $error("new request accepted while answer pending");
   property p_rdata_byte;
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000;
   endproperty
   a_rdata_byte: assert property (p_rdata_byte)
      else $error("read data has upper bits set");
   property p_apply_rx;
      ((positive_full_scale_apply | negative_full_scale_apply
        | zero_scale_apply) & ~diag_channel_connect) == 4'h0;
   endproperty
   a_apply_rx: assert property (p_apply_rx)
      else $error("test voltage on a channel without receive");
   property p_apply_one;
      ((positive_full_scale_apply & negative_full_scale_apply)
       | (positive_full_scale_apply & zero_scale_apply)
       | (negative_full_scale_apply & zero_scale_apply)) == 4'h0;
   endproperty
   a_apply_one: assert property (p_apply_one)
      else $error("two test voltages on one channel");
   property p_delay_pairs;
      (delayed_modulator_clock_enable[0] == delayed_modulator_clock_enable[1])
         && (delayed_modulator_clock_enable[2]
             == delayed_modulator_clock_enable[3]);
   endproperty
   a_delay_pairs: assert property (p_delay_pairs)
      else $error("delayed clock not enabled in channel pairs");
endmodule
bind adc_diag_config adc_diag_checker chk_u (.*);
`default_nettype wire

// >>> verif/adc_diag_config_tb.sv
/*
 Self-checking bench for the register bank over AXI4-Lite.
 Assumes the bound checker and a 40 MHz aclk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "adc_diag_defs.vh"
module adc_diag_config_tb;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [8:0]  s_axi_awaddr = 9'h000;
   logic [2:0]  s_axi_awprot = 3'h0;
   logic        s_axi_awvalid = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic        s_axi_wvalid = 1'b0;
   logic        s_axi_bready = 1'b0;
   logic [8:0]  s_axi_araddr = 9'h000;
   logic [2:0]  s_axi_arprot = 3'h0;
   logic        s_axi_arvalid = 1'b0;
   logic        s_axi_rready = 1'b0;
   wire         s_axi_awready, s_axi_wready, s_axi_bvalid;
   wire         s_axi_arready, s_axi_rvalid;
   wire  [1:0]  s_axi_bresp, s_axi_rresp;
   wire  [31:0] s_axi_rdata;
   wire  [3:0]  diag_channel_connect, positive_full_scale_apply;
   wire  [3:0]  negative_full_scale_apply, zero_scale_apply;
   wire  [3:0]  delayed_modulator_clock_enable, channel_chop;
   int          error_cnt = 0;
   int          tests_run = 0;
   adc_diag_config #(.ADDR_W(9)) dut_u (.*);
   always #12.5 aclk = ~aclk;
   task chk(input logic [31:0] got, input logic [31:0] exp, input string s);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: %s got %h exp %h", $time, s, got, exp);
      end
   endtask
   function automatic logic [8:0] ba(input logic [6:0] i);
      return {i, 2'b00};
   endfunction
   task wr(input logic [6:0] i, input logic [7:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_awaddr <= ba(i);
      s_axi_wdata <= {24'h00_0000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      r = 2'h3;
      while (r === 2'h3) begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) begin
            r = s_axi_bresp;
            s_axi_bready <= 1'b0;
         end
      end
   endtask
   task rd(input logic [6:0] i, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= ba(i);
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      r = 2'h3;
      while (r === 2'h3) begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) begin
            r = s_axi_rresp;
            d = s_axi_rdata;
            s_axi_rready <= 1'b0;
         end
      end
   endtask
   task t_reset;
      logic [31:0] d;
      logic [1:0]  r;
      rd(`DIAG_MUX_CONTROL_IDX, d, r);
      chk(d, 32'h0000_0000, "mux reset");
      rd(`MOD_DELAY_CONTROL_IDX, d, r);
      chk(d, 32'h0000_0002, "delay reset");
      rd(`CHOP_RATE_CONTROL_IDX, d, r);
      chk(d, 32'h0000_000a, "chop reset");
      chk({positive_full_scale_apply, negative_full_scale_apply,
           zero_scale_apply, delayed_modulator_clock_enable}, 0, "idle");
      $display("test reset done");
   endtask
   task t_regs;
      logic [31:0] d;
      logic [1:0]  r;
      wr(`DIAG_MUX_CONTROL_IDX, 8'hff, r);
      rd(`DIAG_MUX_CONTROL_IDX, d, r);
      chk(d, 32'h0000_0077, "mux fields");
      wr(`CHOP_RATE_CONTROL_IDX, 8'h05, r);
      rd(`CHOP_RATE_CONTROL_IDX, d, r);
      chk({r, d[7:0]}, {`RESP_OKAY, 8'h05}, "chop fields");
      s_axi_wstrb <= 4'h0;
      wr(`CHOP_RATE_CONTROL_IDX, 8'h0a, r);
      s_axi_wstrb <= 4'hf;
      chk(r, `RESP_OKAY, "clear strobe answer");
      rd(`CHOP_RATE_CONTROL_IDX, d, r);
      chk(d, 32'h0000_0005, "clear strobe keeps chop");
      wr(7'h7f, 8'hff, r);
      chk(r, `RESP_SLVERR, "unmapped write");
      rd(7'h7f, d, r);
      chk({r, d}, {`RESP_SLVERR, 32'h0000_0000}, "unmapped read");
      $display("test registers done");
   endtask
   // channels 1 and 3 in group b; channel 1 receive off
   function automatic logic [3:0] hit(input logic [2:0] a, b, c);
      return ((a === c ? 4'h5 : 4'h0) | (b === c ? 4'ha : 4'h0)) & 4'hd;
   endfunction
   task t_diag;
      logic [2:0] codes [5];
      logic [2:0] a, b;
      logic [1:0] r;
      codes = '{3'h0, 3'h3, 3'h4, 3'h5, 3'h7};
      wr(`GROUP_ASSIGN_IDX, 8'h0a, r);
      wr(`DIAG_RX_SELECT_IDX, 8'h31, r);
      repeat (2) @(posedge aclk);
      chk(diag_channel_connect, 4'hd, "receive select");
      for (int i = 0; i < 5; i++) begin
         a = codes[i];
         b = codes[(i + 1) % 5];
         wr(`DIAG_MUX_CONTROL_IDX, {1'b0, b, 1'b0, a}, r);
         repeat (2) @(posedge aclk);
         chk(positive_full_scale_apply, hit(a, b, 3'h3), "pos");
         chk(negative_full_scale_apply, hit(a, b, 3'h4), "neg");
         chk(zero_scale_apply, hit(a, b, 3'h5), "zero");
      end
      $display("test diagnostic done");
   endtask
   task t_delay;
      logic [3:0] e [4];
      logic [1:0] r;
      e = '{4'h0, 4'h3, 4'hc, 4'hf};
      for (int c = 0; c < 4; c++) begin
         wr(`MOD_DELAY_CONTROL_IDX, {4'h0, c[1:0], 2'b10}, r);
         repeat (2) @(posedge aclk);
         chk(delayed_modulator_clock_enable, e[c], "delay");
      end
      $display("test delay done");
   endtask
   // skips two edges so a phase restart cannot shorten the measurement
   task half(input int b, input int e, input string s);
      int  n;
      logic v;
      @(posedge aclk);
      repeat (2) begin
         v = channel_chop[b];
         for (n = 0; n < 100 && channel_chop[b] === v; n++) @(posedge aclk);
      end
      v = channel_chop[b];
      for (n = 0; n < 100 && channel_chop[b] === v; n++) @(posedge aclk);
      chk(n, e, s);
   endtask
   task t_chop;
      logic [1:0] r;
      wr(`CHOP_RATE_CONTROL_IDX, 8'h06, r);
      half(0, 4, "group a half period");
      half(1, 16, "group b half period");
      wr(`CHOP_RATE_CONTROL_IDX, 8'h00, r);
      repeat (4) @(posedge aclk);
      chk(channel_chop, 4'h0, "chop off");
      $display("test chop done");
   endtask
   task end_sim;
      $display("counts: %0d checks, %0d mismatches", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset;
      t_regs;
      t_diag;
      t_delay;
      t_chop;
      end_sim;
   end
   // whole run is well under two thousand cycles
   initial begin
      repeat (20000) @(posedge aclk);
      error_cnt++;
      $display("wrong value at %0t: watchdog expired", $time);
      end_sim;
   end
endmodule
`default_nettype wire
